//--- design/device_descriptor_tlv_rom.sv
// Descriptor record block: APB slave in front of a read-only byte image.
// Assumes an APB3 master on core_clk_i and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - After the leading information block, the image is a chain of records, each a tag byte, a length byte, then that many data bytes.
// - The first byte reads 06h as information length and the second 06h as checksum length.
// - The two bytes after the length bytes hold a per-unit 16-bit checksum.
// - A 16-bit part code follows, low byte at the lower location, high byte at the next.
// - One silicon revision byte and then one firmware revision byte follow, both per unit.
// - The die-trace record starts with tag 08h and length 0Ah.
// - Die-trace data is lot/wafer (4 bytes), die X (2), die Y (2) and test results (2).
// - The converter record starts with tag 11h and length 10h.
// - Converter data is gain, offset and six sensor readings, 16 bits each.
// - The reference record is tag 12h, length 06h and three 16-bit corrections.
// - The seed record is tag 15h, length 10h and a 128-bit per-unit value.
module device_descriptor_tlv_rom
    import descriptor_pkg::*;
#(
    parameter int unsigned ADDR_W = 16,
    // Arbitrary part code
    parameter logic [IDX_W-1:0] PART_ID = 16'hA5C3,
    parameter logic [ROM_BYTES*BYTE_W-1:0] UNIT_IMAGE = {ROM_BYTES{8'h5A}}
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    output logic pready_o,
    output logic [DATA_W-1:0] prdata_o,
    output logic pslverr_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < IDX_W || ADDR_W > DATA_W) begin : g_bad_addr_w
        $error("ADDR_W must cover the register map and fit the bus");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    slave_state_t state_reg;
    slave_state_t state_next;
    apb_req_t req;
    logic [ADDR_W-1:0] index_full;
    logic [ROM_OFF_W-1:0] rom_offset;
    logic [BYTE_W-1:0] rom_byte;
    logic in_rom;
    logic is_ctrl;
    logic is_status;
    logic is_fault;
    logic setup_phase;
    logic access_phase;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] fault_word;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    assign index_full = paddr_i >> IDX_SHIFT;

    always_comb begin
        req.sel = psel_i;
        req.enable = penable_i;
        req.write = pwrite_i;
        req.aligned = (paddr_i[IDX_SHIFT-1:0] == '0);
        req.index = index_full[IDX_W-1:0];
    end

    assign setup_phase = req.sel && !req.enable;
    assign access_phase = req.sel && req.enable;

    // Upper index bits must be clear so the map does not alias
    always_comb begin
        in_rom = (index_full >= ADDR_W'(IDX_ROM_BASE)) && (index_full <= ADDR_W'(IDX_ROM_LAST));
        is_ctrl = (index_full == ADDR_W'(IDX_CTRL));
        is_status = (index_full == ADDR_W'(IDX_STATUS));
        is_fault = (index_full == ADDR_W'(IDX_FAULT));
    end

    assign rom_offset = req.index[ROM_OFF_W-1:0];

    // ------------------------------------------------------------
    // Descriptor image
    // ------------------------------------------------------------
    descriptor_byte_store #(
        .PART_ID(PART_ID),
        .UNIT_IMAGE(UNIT_IMAGE)
    ) u_store (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .offset_i(rom_offset),
        .byte_o(rom_byte)
    );

    // ------------------------------------------------------------
    // Read words of the local registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_STRICT_BIT] = state_reg.strict;
        status_word = '0;
        status_word[STATUS_WRITE_SEEN_BIT] = state_reg.write_seen;
        status_word[STATUS_UNMAPPED_BIT] = state_reg.unmapped_seen;
        status_word[STATUS_COUNT_LSB +: COUNT_W] = state_reg.reject_count;
        fault_word = '0;
        fault_word[IDX_W-1:0] = state_reg.fault_index;
    end

    // ------------------------------------------------------------
    // Transfer sequencer and register updates
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg.state)
            ST_IDLE: begin
                state_next.ready = 1'b0;
                state_next.slverr = 1'b0;
                if (setup_phase) begin
                    state_next.state = ST_FETCH;
                    state_next.is_write = req.write;
                    state_next.err = 1'b0;
                    if (!req.aligned) begin
                        state_next.src = SRC_NONE;
                        state_next.err = 1'b1;
                    end else if (in_rom) begin
                        state_next.src = SRC_ROM;
                        // Refused write reports only when strict
                        state_next.err = req.write && state_reg.strict;
                    end else if (is_ctrl) begin
                        state_next.src = SRC_CTRL;
                    end else if (is_status) begin
                        state_next.src = SRC_STATUS;
                        state_next.err = req.write && state_reg.strict;
                    end else if (is_fault) begin
                        state_next.src = SRC_FAULT;
                        state_next.err = req.write && state_reg.strict;
                    end else begin
                        state_next.src = SRC_NONE;
                        state_next.err = 1'b1;
                    end
                end
            end
            ST_FETCH: begin
                if (!req.sel) begin
                    // Master withdrew; drop the transfer
                    state_next.state = ST_IDLE;
                end else begin
                    state_next.state = ST_ANSWER;
                    state_next.ready = 1'b1;
                    state_next.slverr = state_reg.err;
                    state_next.rdata = '0;
                    if (!state_reg.is_write) begin
                        case (state_reg.src)
                            SRC_ROM: begin
                                // Byte in the low lane, upper lanes zero
                                state_next.rdata[BYTE_W-1:0] = rom_byte;
                            end
                            SRC_CTRL: begin
                                state_next.rdata = ctrl_word;
                            end
                            SRC_STATUS: begin
                                state_next.rdata = status_word;
                            end
                            SRC_FAULT: begin
                                state_next.rdata = fault_word;
                            end
                            default: begin
                                state_next.rdata = '0;
                            end
                        endcase
                    end
                end
            end
            ST_ANSWER: begin
                if (access_phase) begin
                    // Completion edge: writes and events land here only
                    state_next.state = ST_IDLE;
                    state_next.ready = 1'b0;
                    state_next.slverr = 1'b0;
                    if (state_reg.is_write && state_reg.src == SRC_CTRL) begin
                        state_next.strict = pwdata_i[CTRL_STRICT_BIT];
                        if (pwdata_i[CTRL_CLEAR_BIT]) begin
                            state_next.write_seen = 1'b0;
                            state_next.unmapped_seen = 1'b0;
                            state_next.reject_count = '0;
                        end
                    end
                    // Sets follow clears so a same-edge event survives
                    if (state_reg.is_write && state_reg.src != SRC_CTRL
                        && state_reg.src != SRC_NONE) begin
                        // Descriptor contents are never touched
                        state_next.write_seen = 1'b1;
                        state_next.fault_index = req.index;
                        if (state_reg.reject_count != '1) begin
                            state_next.reject_count = state_reg.reject_count + COUNT_W'(1);
                        end
                    end
                    if (state_reg.src == SRC_NONE) begin
                        state_next.unmapped_seen = 1'b1;
                        state_next.fault_index = req.index;
                        if (state_reg.reject_count != '1) begin
                            state_next.reject_count = state_reg.reject_count + COUNT_W'(1);
                        end
                    end
                end else if (!req.sel) begin
                    state_next.state = ST_IDLE;
                    state_next.ready = 1'b0;
                    state_next.slverr = 1'b0;
                end
            end
            default: begin
                state_next.state = ST_IDLE;
                state_next.ready = 1'b0;
                state_next.slverr = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg.state <= ST_IDLE;
            state_reg.src <= SRC_NONE;
            state_reg.is_write <= 1'b0;
            state_reg.err <= 1'b0;
            state_reg.ready <= 1'b0;
            state_reg.slverr <= 1'b0;
            state_reg.rdata <= '0;
            state_reg.strict <= RST_CTRL_STRICT;
            state_reg.write_seen <= 1'b0;
            state_reg.unmapped_seen <= 1'b0;
            state_reg.reject_count <= '0;
            state_reg.fault_index <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign pready_o = state_reg.ready;
    assign prdata_o = state_reg.rdata;
    assign pslverr_o = state_reg.slverr;

endmodule

`default_nettype wire

//--- design/descriptor_pkg.sv
// Shared constants and types for the descriptor record block.
// Assumes one clock domain and a 32-bit APB slave port.
package descriptor_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned IDX_W = 16;
    localparam int unsigned IDX_SHIFT = 2;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned ROM_BYTES = 64;
    localparam int unsigned ROM_OFF_W = 6;
    localparam int unsigned COUNT_W = 8;

    // ------------------------------------------------------------
    // Register indices (byte address is index times four)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_ROM_BASE = 16'h1A00;
    localparam logic [IDX_W-1:0] IDX_INFO_BLOCK_LENGTH = 16'h1A00;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM_LENGTH = 16'h1A01;
    localparam logic [IDX_W-1:0] IDX_CHECKSUM_VALUE = 16'h1A02;
    localparam logic [IDX_W-1:0] IDX_PART_IDENTIFICATION = 16'h1A04;
    localparam logic [IDX_W-1:0] IDX_PART_IDENTIFICATION_HIGH = 16'h1A05;
    localparam logic [IDX_W-1:0] IDX_SILICON_REVISION = 16'h1A06;
    localparam logic [IDX_W-1:0] IDX_FIRMWARE_REVISION = 16'h1A07;
    localparam logic [IDX_W-1:0] IDX_DIE_TRACE_TAG = 16'h1A08;
    localparam logic [IDX_W-1:0] IDX_DIE_TRACE_LENGTH = 16'h1A09;
    localparam logic [IDX_W-1:0] IDX_LOT_WAFER_IDENTIFIER = 16'h1A0A;
    localparam logic [IDX_W-1:0] IDX_DIE_X_POSITION = 16'h1A0E;
    localparam logic [IDX_W-1:0] IDX_DIE_Y_POSITION = 16'h1A10;
    localparam logic [IDX_W-1:0] IDX_PRODUCTION_TEST_RESULTS = 16'h1A12;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_CAL_TAG = 16'h1A14;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_CAL_LENGTH = 16'h1A15;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_GAIN_FACTOR = 16'h1A16;
    localparam logic [IDX_W-1:0] IDX_CONVERTER_OFFSET_FACTOR = 16'h1A18;
    localparam logic [IDX_W-1:0] IDX_TEMP_LOW_REF1_READING = 16'h1A1A;
    localparam logic [IDX_W-1:0] IDX_TEMP_HIGH_REF1_READING = 16'h1A1C;
    localparam logic [IDX_W-1:0] IDX_TEMP_LOW_REF2_READING = 16'h1A1E;
    localparam logic [IDX_W-1:0] IDX_TEMP_HIGH_REF2_READING = 16'h1A20;
    localparam logic [IDX_W-1:0] IDX_TEMP_LOW_REF3_READING = 16'h1A22;
    localparam logic [IDX_W-1:0] IDX_TEMP_HIGH_REF3_READING = 16'h1A24;
    localparam logic [IDX_W-1:0] IDX_REFERENCE_CAL_TAG = 16'h1A26;
    localparam logic [IDX_W-1:0] IDX_REFERENCE_CAL_LENGTH = 16'h1A27;
    localparam logic [IDX_W-1:0] IDX_REFERENCE1_CORRECTION = 16'h1A28;
    localparam logic [IDX_W-1:0] IDX_REFERENCE2_CORRECTION = 16'h1A2A;
    localparam logic [IDX_W-1:0] IDX_REFERENCE3_CORRECTION = 16'h1A2C;
    localparam logic [IDX_W-1:0] IDX_RANDOM_SEED_TAG = 16'h1A2E;
    localparam logic [IDX_W-1:0] IDX_RANDOM_SEED_LENGTH = 16'h1A2F;
    localparam logic [IDX_W-1:0] IDX_RANDOM_SEED_VALUE = 16'h1A30;
    localparam logic [IDX_W-1:0] IDX_ROM_LAST = 16'h1A3F;
    localparam logic [IDX_W-1:0] IDX_CTRL = 16'h1A40;
    localparam logic [IDX_W-1:0] IDX_STATUS = 16'h1A41;
    localparam logic [IDX_W-1:0] IDX_FAULT = 16'h1A42;

    // ------------------------------------------------------------
    // Fixed record bytes
    // ------------------------------------------------------------
    localparam logic [BYTE_W-1:0] VAL_INFO_BLOCK_LENGTH = 8'h06;
    localparam logic [BYTE_W-1:0] VAL_CHECKSUM_LENGTH = 8'h06;
    localparam logic [BYTE_W-1:0] VAL_DIE_TRACE_TAG = 8'h08;
    localparam logic [BYTE_W-1:0] VAL_DIE_TRACE_LENGTH = 8'h0A;
    localparam logic [BYTE_W-1:0] VAL_CONVERTER_CAL_TAG = 8'h11;
    localparam logic [BYTE_W-1:0] VAL_CONVERTER_CAL_LENGTH = 8'h10;
    localparam logic [BYTE_W-1:0] VAL_REFERENCE_CAL_TAG = 8'h12;
    localparam logic [BYTE_W-1:0] VAL_REFERENCE_CAL_LENGTH = 8'h06;
    localparam logic [BYTE_W-1:0] VAL_RANDOM_SEED_TAG = 8'h15;
    localparam logic [BYTE_W-1:0] VAL_RANDOM_SEED_LENGTH = 8'h10;

    // ------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------
    localparam int unsigned CTRL_STRICT_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;
    localparam int unsigned STATUS_WRITE_SEEN_BIT = 0;
    localparam int unsigned STATUS_UNMAPPED_BIT = 1;
    localparam int unsigned STATUS_COUNT_LSB = 8;
    localparam logic RST_CTRL_STRICT = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_ANSWER = 2'b10
    } apb_state_t;

    typedef enum logic [2:0] {
        SRC_ROM = 3'b000,
        SRC_CTRL = 3'b001,
        SRC_STATUS = 3'b010,
        SRC_FAULT = 3'b011,
        SRC_NONE = 3'b100
    } read_src_t;

    typedef struct packed {
        logic fixed;
        logic [BYTE_W-1:0] value;
    } fixed_byte_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic aligned;
        logic [IDX_W-1:0] index;
    } apb_req_t;

    typedef struct packed {
        apb_state_t state;
        read_src_t src;
        logic is_write;
        logic err;
        logic ready;
        logic slverr;
        logic [DATA_W-1:0] rdata;
        logic strict;
        logic write_seen;
        logic unmapped_seen;
        logic [COUNT_W-1:0] reject_count;
        logic [IDX_W-1:0] fault_index;
    } slave_state_t;

    // Tag and length bytes that every unit carries unchanged
    function automatic fixed_byte_t fixed_byte(input logic [IDX_W-1:0] idx);
        fixed_byte_t fb;
        fb = '{fixed: 1'b1, value: '0};
        case (idx)
            IDX_INFO_BLOCK_LENGTH: fb.value = VAL_INFO_BLOCK_LENGTH;
            IDX_CHECKSUM_LENGTH: fb.value = VAL_CHECKSUM_LENGTH;
            IDX_DIE_TRACE_TAG: fb.value = VAL_DIE_TRACE_TAG;
            IDX_DIE_TRACE_LENGTH: fb.value = VAL_DIE_TRACE_LENGTH;
            IDX_CONVERTER_CAL_TAG: fb.value = VAL_CONVERTER_CAL_TAG;
            IDX_CONVERTER_CAL_LENGTH: fb.value = VAL_CONVERTER_CAL_LENGTH;
            IDX_REFERENCE_CAL_TAG: fb.value = VAL_REFERENCE_CAL_TAG;
            IDX_REFERENCE_CAL_LENGTH: fb.value = VAL_REFERENCE_CAL_LENGTH;
            IDX_RANDOM_SEED_TAG: fb.value = VAL_RANDOM_SEED_TAG;
            IDX_RANDOM_SEED_LENGTH: fb.value = VAL_RANDOM_SEED_LENGTH;
            default: fb.fixed = 1'b0;
        endcase
        return fb;
    endfunction

endpackage

//--- design/descriptor_byte_store.sv
// Byte-wide descriptor image with a registered read port.
// Assumes the offset is held stable for the cycle before the data is used.
`timescale 1ns/1ps
`default_nettype none

module descriptor_byte_store
    import descriptor_pkg::*;
#(
    // Arbitrary part code
    parameter logic [IDX_W-1:0] PART_ID = 16'hA5C3,
    parameter logic [ROM_BYTES*BYTE_W-1:0] UNIT_IMAGE = {ROM_BYTES{8'h5A}}
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [ROM_OFF_W-1:0] offset_i,
    output logic [BYTE_W-1:0] byte_o
);

    // ------------------------------------------------------------
    // Image assembly
    // ------------------------------------------------------------
    logic [BYTE_W-1:0] rom [ROM_BYTES];
    logic [BYTE_W-1:0] byte_reg;
    logic [BYTE_W-1:0] byte_next;

    for (genvar i = 0; i < ROM_BYTES; i++) begin : g_entry
        localparam logic [IDX_W-1:0] ENTRY_IDX = IDX_ROM_BASE + IDX_W'(i);
        localparam fixed_byte_t FIXED = fixed_byte(ENTRY_IDX);
        if (FIXED.fixed) begin : g_fixed
            assign rom[i] = FIXED.value;
        end else if (ENTRY_IDX == IDX_PART_IDENTIFICATION) begin : g_id_low
            assign rom[i] = PART_ID[BYTE_W-1:0];
        end else if (ENTRY_IDX == IDX_PART_IDENTIFICATION_HIGH) begin : g_id_high
            assign rom[i] = PART_ID[2*BYTE_W-1:BYTE_W];
        end else begin : g_unit
            assign rom[i] = UNIT_IMAGE[i*BYTE_W +: BYTE_W];
        end
    end

    // ------------------------------------------------------------
    // Read register
    // ------------------------------------------------------------
    always_comb begin
        byte_next = rom[offset_i];
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            byte_reg <= '0;
        end else begin
            byte_reg <= byte_next;
        end
    end

    assign byte_o = byte_reg;

endmodule

`default_nettype wire

//--- testbench/descriptor_rom_checker_sva.sv
// Bus timing and fixed record checks for the descriptor block.
// Assumes it is bound to the ports of the block's top module.
`timescale 1ns/1ps
`default_nettype none

module descriptor_rom_checker
    import descriptor_pkg::*;
#(
    parameter int unsigned ADDR_W = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [DATA_W-1:0] pwdata_i,
    input wire logic pready_o,
    input wire logic [DATA_W-1:0] prdata_o,
    input wire logic pslverr_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    logic rd_ans;
    assign rd_ans = pready_o && !pwrite_i;

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_answer_delay;
        (psel_i && !penable_i) ##1 (psel_i && penable_i) |-> ##1 pready_o;
    endproperty
    a_answer_delay: assert property (p_answer_delay) else $error("answer not in second access cycle");
    property p_ready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_err_with_ready;
        pslverr_o |-> pready_o;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_ready_in_access;
        pready_o |-> psel_i && penable_i && $past(penable_i);
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access phase");
    property p_byte_lane;
        rd_ans && paddr_i >= 16'h6800 && paddr_i <= 16'h68FC && paddr_i[1:0] == 2'b00
            |-> prdata_o[31:8] == 24'h0 && !pslverr_o;
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("record read not one clean byte");
    property p_info_len;
        rd_ans && paddr_i == 16'h6800 |-> prdata_o == 32'h0000_0006;
    endproperty
    a_info_len: assert property (p_info_len) else $error("info length wrong");
    property p_die_tag;
        rd_ans && paddr_i == 16'h6820 |-> prdata_o == 32'h0000_0008;
    endproperty
    a_die_tag: assert property (p_die_tag) else $error("die trace tag wrong");
    property p_conv_tag;
        rd_ans && paddr_i == 16'h6850 |-> prdata_o == 32'h0000_0011;
    endproperty
    a_conv_tag: assert property (p_conv_tag) else $error("converter tag wrong");
    property p_ref_tag;
        rd_ans && paddr_i == 16'h6898 |-> prdata_o == 32'h0000_0012;
    endproperty
    a_ref_tag: assert property (p_ref_tag) else $error("reference tag wrong");
    property p_seed_tag;
        rd_ans && paddr_i == 16'h68B8 |-> prdata_o == 32'h0000_0015;
    endproperty
    a_seed_tag: assert property (p_seed_tag) else $error("seed tag wrong");

    c_info_read: cover property (rd_ans && paddr_i == 16'h6800);
    c_refused_write: cover property (pready_o && pwrite_i && pslverr_o);
    c_misaligned: cover property (pready_o && paddr_i[1:0] != 2'b00);
endmodule

bind device_descriptor_tlv_rom descriptor_rom_checker #(.ADDR_W(ADDR_W)) descriptor_rom_checker_i (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .pready_o(pready_o),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o)
);
`default_nettype wire

//--- testbench/device_descriptor_tlv_rom_tb.sv
// Self-checking bench for the descriptor block over APB.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`default_nettype none

module device_descriptor_tlv_rom_tb;
    import descriptor_pkg::*;
    // Arbitrary part code
    localparam logic [IDX_W-1:0] TB_PART_ID = 16'h3C96;
    function automatic logic [ROM_BYTES*BYTE_W-1:0] make_image();
        logic [ROM_BYTES*BYTE_W-1:0] img;
        for (int i = 0; i < ROM_BYTES; i++) begin
            img[8*i+:8] = 8'(i) ^ 8'hC3;
        end
        return img;
    endfunction
    localparam logic [ROM_BYTES*BYTE_W-1:0] TB_IMAGE = make_image();
    logic core_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [15:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    int miscompares, tests_run;

    device_descriptor_tlv_rom #(.ADDR_W(16), .PART_ID(TB_PART_ID), .UNIT_IMAGE(TB_IMAGE)) device_descriptor_tlv_rom_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o));

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    function automatic logic [7:0] exp_byte(input logic [5:0] off);
        case (off)
            6'h00, 6'h01, 6'h27: exp_byte = 8'h06;
            6'h04: exp_byte = TB_PART_ID[7:0];
            6'h05: exp_byte = TB_PART_ID[15:8];
            6'h08: exp_byte = 8'h08;
            6'h09: exp_byte = 8'h0A;
            6'h14: exp_byte = 8'h11;
            6'h15, 6'h2F: exp_byte = 8'h10;
            6'h26: exp_byte = 8'h12;
            6'h2E: exp_byte = 8'h15;
            default: exp_byte = TB_IMAGE[8*off+:8];
        endcase
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, left selected so the next may follow at once
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                        input logic [31:0] exp, input logic err, input string what);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= addr;
        pwdata_i <= wd;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 8);
        if (pready_o !== 1'b1) begin
            miscompares++;
            report_and_stop();
        end
        check(what, prdata_o, exp);
        check({what, " error"}, {31'h0, pslverr_o}, {31'h0, err});
    endtask

    task automatic idle();
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic s_read_all();
        for (int i = 0; i < ROM_BYTES; i++) begin
            xfer(1'b0, 16'h6800 + 16'(4 * i), 32'h0, {24'h0, exp_byte(6'(i))}, 1'b0, "record byte");
        end
        idle();
    endtask

    task automatic s_refused_writes();
        xfer(1'b1, 16'h6800, 32'hFFFF_FFFF, 32'h0, 1'b1, "info write");
        xfer(1'b1, 16'h68C0, 32'h0000_00AA, 32'h0, 1'b1, "seed write");
        xfer(1'b0, 16'h6800, 32'h0, 32'h0000_0006, 1'b0, "info after write");
        xfer(1'b0, 16'h68C0, 32'h0, {24'h0, exp_byte(6'h30)}, 1'b0, "seed after write");
        xfer(1'b0, 16'h6904, 32'h0, 32'h0000_0201, 1'b0, "status");
        xfer(1'b0, 16'h6908, 32'h0, 32'h0000_1A30, 1'b0, "fault");
        idle();
    endtask

    task automatic s_lenient_mode();
        xfer(1'b1, 16'h6900, 32'h0, 32'h0, 1'b0, "ctrl lenient");
        xfer(1'b1, 16'h6810, 32'h0000_5555, 32'h0, 1'b0, "lenient write");
        xfer(1'b0, 16'h6810, 32'h0, {24'h0, TB_PART_ID[7:0]}, 1'b0, "part low");
        xfer(1'b1, 16'h6900, 32'h0000_0003, 32'h0, 1'b0, "ctrl strict clear");
        xfer(1'b0, 16'h6904, 32'h0, 32'h0, 1'b0, "status cleared");
        xfer(1'b0, 16'h6900, 32'h0, 32'h0000_0001, 1'b0, "ctrl");
        idle();
    endtask

    task automatic s_unmapped();
        xfer(1'b0, 16'h690C, 32'h0, 32'h0, 1'b1, "unmapped");
        xfer(1'b0, 16'h6801, 32'h0, 32'h0, 1'b1, "misaligned");
        xfer(1'b0, 16'h6904, 32'h0, 32'h0000_0202, 1'b0, "status unmapped");
        xfer(1'b0, 16'h6908, 32'h0, 32'h0000_1A00, 1'b0, "fault misaligned");
        idle();
    endtask

    initial begin
        reset_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 16'h0;
        pwdata_i = 32'h0;
        miscompares = 0;
        tests_run = 0;
        repeat (16) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        s_read_all();
        s_refused_writes();
        s_lenient_mode();
        s_unmapped();
        report_and_stop();
    end
endmodule
`default_nettype wire
